/* expander_read_path.sv */
/*
 * Slave side of the two-wire serial bus for an 8-bit I/O expander: address
 * match, command pointer, register read-back and byte capture on acknowledge.
 * Assumes scl/sda come from outside the mclk domain and are oversampled;
 * SDA is open drain, low-drive only. Data bytes for the output, polarity and
 * config registers pass through a FIFO that the register side drains; a full
 * FIFO makes the device refuse (NACK) them, but not command bytes.
 */
`timescale 1ns/1ps
`default_nettype none
`include "expander_regs.svh"
module expander_read_path
    import expander_pkg::*;
#(
    parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic [2:0] addr_select_pins,
    input wire logic [7:0] port_pins,
    output logic [7:0] port_out,
    output logic [7:0] port_dir,
    output logic [7:0] port_polarity
);
    // ==========================================================
    // Synchronisers
    logic [1:0] scl_sync_q, sda_sync_q;
    logic scl_prev_q, sda_prev_q;
    logic [7:0] pins_meta_q, pins_q;
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            scl_sync_q <= 2'b11;
            sda_sync_q <= 2'b11;
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
            pins_meta_q <= 8'h00;
            pins_q <= 8'h00;
        end
        else
        begin
            scl_sync_q <= {scl_sync_q[0], scl_in};
            sda_sync_q <= {sda_sync_q[0], sda_in};
            scl_prev_q <= scl_sync_q[1];
            sda_prev_q <= sda_sync_q[1];
            pins_meta_q <= port_pins;
            pins_q <= pins_meta_q;
        end
    end

    logic scl_s, sda_s, scl_rise, scl_fall, start_cond, stop_cond;
    assign scl_s = scl_sync_q[1];
    assign sda_s = sda_sync_q[1];
    assign scl_rise = scl_s && !scl_prev_q;
    assign scl_fall = !scl_s && scl_prev_q;
    assign start_cond = scl_s && scl_prev_q && sda_prev_q && !sda_s;
    assign stop_cond = scl_s && scl_prev_q && !sda_prev_q && sda_s;

    // Register select decode, used for read-back only
    function automatic logic [7:0] reg_select(input logic [1:0] ptr,
        input logic [7:0] pins, input port_regs_s r);
        case (ptr)
            `PTR_INPUT: reg_select = pins;
            `PTR_OUTPUT: reg_select = r.output_port;
            `PTR_POLARITY: reg_select = r.polarity;
            default: reg_select = r.config_dir;
        endcase
    endfunction

    // ==========================================================
    // Bus state machine
    bus_state_e st_q, st_d;
    logic [7:0] sh_q, sh_d;
    logic [2:0] bit_q, bit_d;
    logic [1:0] ptr_q, ptr_d;
    logic rd_q, rd_d, cmd_q, cmd_d, drive_q, drive_d, ack_q, ack_d;
    // Set once eight bits are in; bit_q alone wraps to 0 and looks empty
    logic full_q, full_d;
    logic fifo_in_valid, fifo_in_ready, fifo_out_valid;
    logic [9:0] fifo_out_data;
    logic [9:0] fifo_in_data;

    always_comb
    begin
        st_d = st_q;
        sh_d = sh_q;
        bit_d = bit_q;
        ptr_d = ptr_q;
        rd_d = rd_q;
        cmd_d = cmd_q;
        drive_d = drive_q;
        ack_d = ack_q;
        full_d = full_q;
        fifo_in_valid = 1'b0;
        fifo_in_data = {ptr_q, sh_q};
        if (start_cond)
        begin
            // Pointer kept across restart
            st_d = ST_ADDR;
            bit_d = 3'd0;
            full_d = 1'b0;
            drive_d = 1'b0;
        end
        else if (stop_cond)
        begin
            // Unfinished byte dropped, latched registers kept
            st_d = ST_IDLE;
            full_d = 1'b0;
            drive_d = 1'b0;
        end
        else
        begin
            case (st_q)
                ST_IDLE: st_d = ST_IDLE;
                ST_ADDR, ST_RX:
                begin
                    if (scl_rise)
                    begin
                        sh_d = {sh_q[6:0], sda_s};
                        bit_d = bit_q + 3'd1;
                        full_d = (bit_q == 3'd7);
                    end
                    if (scl_fall)
                        full_d = 1'b0;
                    if (scl_fall && full_q && st_q == ST_ADDR
                        && sh_q[7:1] == {`ADDR_BASE, addr_select_pins})
                    begin
                        rd_d = sh_q[0];
                        cmd_d = !sh_q[0];
                        drive_d = 1'b1;
                        ack_d = 1'b1;
                        st_d = ST_ADDR_ACK;
                    end
                    else if (scl_fall && full_q && st_q == ST_ADDR)
                        st_d = ST_IDLE;
                    else if (scl_fall && full_q)
                    begin
                        // Refuse when writes cannot be stored
                        drive_d = cmd_q || (ptr_q == `PTR_INPUT) || fifo_in_ready;
                        ack_d = drive_d;
                        st_d = ST_RX_ACK;
                    end
                end
                ST_ADDR_ACK:
                begin
                    if (scl_fall)
                    begin
                        if (rd_q)
                        begin
                            sh_d = reg_select(ptr_q, pins_q ^ port_polarity,
                                {port_out, port_polarity, port_dir});
                            drive_d = !sh_d[7];
                            ack_d = 1'b0;
                            bit_d = 3'd1;
                            st_d = ST_TX;
                        end
                        else
                        begin
                            drive_d = 1'b0;
                            bit_d = 3'd0;
                            st_d = ST_RX;
                        end
                    end
                end
                ST_RX_ACK:
                begin
                    if (scl_rise && ack_q)
                    begin
                        if (cmd_q)
                        begin
                            ptr_d = sh_q[1:0];
                            cmd_d = 1'b0;
                        end
                        else if (ptr_q != `PTR_INPUT)
                            fifo_in_valid = 1'b1;
                    end
                    if (scl_fall)
                    begin
                        drive_d = 1'b0;
                        st_d = ack_q ? ST_RX : ST_IDLE;
                    end
                end
                ST_TX:
                begin
                    if (scl_fall)
                    begin
                        if (bit_q == 3'd0)
                        begin
                            drive_d = 1'b0;
                            st_d = ST_TX_ACK;
                        end
                        else
                        begin
                            drive_d = !sh_q[7 - bit_q];
                            bit_d = bit_q + 3'd1;
                        end
                    end
                end
                ST_TX_ACK:
                begin
                    if (scl_rise)
                        ack_d = !sda_s;
                    if (scl_fall)
                    begin
                        if (ack_q)
                        begin
                            // Master wants more
                            sh_d = reg_select(ptr_q, pins_q ^ port_polarity,
                                {port_out, port_polarity, port_dir});
                            drive_d = !sh_d[7];
                            bit_d = 3'd1;
                            st_d = ST_TX;
                        end
                        else
                            st_d = ST_IDLE;
                    end
                end
                default: st_d = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_q <= ST_IDLE;
            sh_q <= 8'h00;
            bit_q <= 3'd0;
            ptr_q <= `PTR_INPUT;
            rd_q <= 1'b0;
            cmd_q <= 1'b0;
            drive_q <= 1'b0;
            ack_q <= 1'b0;
            full_q <= 1'b0;
        end
        else
        begin
            full_q <= full_d;
            st_q <= st_d;
            sh_q <= sh_d;
            bit_q <= bit_d;
            ptr_q <= ptr_d;
            rd_q <= rd_d;
            cmd_q <= cmd_d;
            drive_q <= drive_d;
            ack_q <= ack_d;
        end
    end

    // Open drain: only ever pulls low
    assign sda_out = 1'b0;
    assign sda_oe = drive_q;

    // ==========================================================
    // Write buffer and register bank
    byte_fifo #(.WIDTH(10), .DEPTH(FIFO_DEPTH)) u_fifo (
        .mclk(mclk),
        .rst_b(rst_b),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in_data),
        .out_valid(fifo_out_valid),
        .out_ready(1'b1),
        .out_data(fifo_out_data)
    );

    port_regs_s regs_q, regs_d;
    always_comb
    begin
        regs_d = regs_q;
        if (fifo_out_valid)
        begin
            case (fifo_out_data[9:8])
                `PTR_OUTPUT: regs_d.output_port = fifo_out_data[7:0];
                `PTR_POLARITY: regs_d.polarity = fifo_out_data[7:0];
                `PTR_CONFIG: regs_d.config_dir = fifo_out_data[7:0];
                default: regs_d = regs_q;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            regs_q <= '{`RST_OUTPUT, `RST_POLARITY, `RST_CONFIG};
        else
            regs_q <= regs_d;
    end

    assign port_out = regs_q.output_port;
    assign port_polarity = regs_q.polarity;
    assign port_dir = regs_q.config_dir;
endmodule
`default_nettype wire

/* expander_regs.svh */
/*
 * Register pointer codes, address constants and sizes for the serial I/O
 * expander read path. Assumes inclusion by every design file that needs them.
 */
// Summary of operation
// - Command byte after write address sets pointer
// - Read address after restart returns selected register
// - Pointer survives repeated start unchanged
// - Data captured at acknowledge clock rising edge
// - Bytes flow while master acknowledges
// - Stop anytime; latched outputs stay, partial input dropped
// - Slave address is 0x18 plus select pins
// - Command low two bits choose register
// - Selection holds until new command byte
// - Input port reads pin levels XOR polarity; writes ignored
`ifndef EXPANDER_REGS_SVH
`define EXPANDER_REGS_SVH

`define ADDR_BASE 4'h3
`define PTR_INPUT 2'h0
`define PTR_OUTPUT 2'h1
`define PTR_POLARITY 2'h2
`define PTR_CONFIG 2'h3
`define RST_OUTPUT 8'h00
`define RST_POLARITY 8'hF0
`define RST_CONFIG 8'hFF
`define FIFO_DEPTH 4

`endif

/* expander_pkg.sv */
/*
 * Types shared by the expander read path.
 * Assumes the constants header is compiled alongside.
 */
package expander_pkg;
    typedef struct packed {
        logic [7:0] output_port;
        logic [7:0] polarity;
        logic [7:0] config_dir;
    } port_regs_s;

    typedef enum logic [6:0] {
        ST_IDLE = 7'b000_0001,
        ST_ADDR = 7'b000_0010,
        ST_ADDR_ACK = 7'b000_0100,
        ST_RX = 7'b000_1000,
        ST_RX_ACK = 7'b001_0000,
        ST_TX = 7'b010_0000,
        ST_TX_ACK = 7'b100_0000
    } bus_state_e;
endpackage

/* byte_fifo.sv */
/*
 * Small flip-flop FIFO with valid/ready on both sides.
 * Assumes a single clock and active-low asynchronous reset.
 */
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    initial
    begin
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
            $error("byte_fifo depth must be a power of two of at least 2");
    end

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0] wr_q, wr_d, rd_q, rd_d;
    logic push, pop;

    // ==========================================================
    // Pointers
    assign in_ready = (wr_q - rd_q) != (AW+1)'(DEPTH);
    assign out_valid = wr_q != rd_q;
    assign out_data = mem_q[rd_q[AW-1:0]];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb
    begin
        wr_d = push ? wr_q + 1'b1 : wr_q;
        rd_d = pop ? rd_q + 1'b1 : rd_q;
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wr_q <= '0;
            rd_q <= '0;
        end
        else
        begin
            wr_q <= wr_d;
            rd_q <= rd_d;
        end
    end

    // Storage is not reset; empty flag guards reads
    always_ff @(posedge mclk)
    begin
        if (push)
            mem_q[wr_q[AW-1:0]] <= in_data;
    end
endmodule
`default_nettype wire

/* expander_read_path_asserts.sv */
/* Port checker for the expander read path.
   Assumes bind onto expander_read_path, one mclk domain. */
`timescale 1ns/1ps
`default_nettype none
module expander_read_path_asserts (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic [7:0] port_out,
    input wire logic [7:0] port_dir,
    input wire logic [7:0] port_polarity
);
    // ========
    // Cycles since the bus clock last moved
    logic scl_q, scl_d;
    logic [4:0] gap_q, gap_d;
    always_comb
    begin
        scl_d = scl_in;
        gap_d = (scl_in != scl_q) ? 5'h0 : gap_q + {4'h0, gap_q != 5'h1f};
    end
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            {scl_q, gap_q} <= 6'h20;
        else
            {scl_q, gap_q} <= {scl_d, gap_d};
    end
    // ========
    // Bus and register checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    property p_od_low; sda_out == 1'b0; endproperty
    a_od_low: assert property (p_od_low) else $error("sda_out high");
    property p_oe_rise_low; $rose(sda_oe) |-> !scl_in; endproperty
    a_oe_rise_low: assert property (p_oe_rise_low) else $error("drive while clock high");
    property p_oe_fall_low; $fell(sda_oe) |-> !scl_in; endproperty
    a_oe_fall_low: assert property (p_oe_fall_low) else $error("release while clock high");
    property p_oe_hold; scl_in && gap_q >= 5'h3 |-> $stable(sda_oe); endproperty
    a_oe_hold: assert property (p_oe_hold) else $error("data moved in clock high");
    property p_reset_vals;
        $rose(rst_b) |-> port_out == 8'h00 && port_dir == 8'hff && port_polarity == 8'hf0
            && !sda_oe;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("bad reset values");
    property p_write_at_ack;
        $changed({port_out, port_dir, port_polarity}) |-> gap_q <= 5'hc;
    endproperty
    a_write_at_ack: assert property (p_write_at_ack) else $error("write off clock edge");
    property p_quiet_after_stop; scl_in && $rose(sda_in) |=> !sda_oe [*8]; endproperty
    a_quiet_after_stop: assert property (p_quiet_after_stop) else $error("drive after stop");
    property p_oe_after_fall; $rose(sda_oe) |-> gap_q <= 5'h6; endproperty
    a_oe_after_fall: assert property (p_oe_after_fall) else $error("late drive");
endmodule
bind expander_read_path expander_read_path_asserts i_chk (.mclk(mclk), .rst_b(rst_b),
    .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .port_out(port_out), .port_dir(port_dir), .port_polarity(port_polarity));
`default_nettype wire

/* i2c_master_model.sv */
/* Behavioural bus master with start, stop, bit and byte tasks.
   Assumes the bench resolves the open-drain data wire. */
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model (
    input wire logic mclk,
    input wire logic sda,
    output logic scl,
    output logic sda_m
);
    // ========
    // Clock 8 mclk low, 8 high; both lines released when idle
    initial
    begin
        scl = 1'b1;
        sda_m = 1'b1;
    end
    task automatic wt(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic start_c;
        sda_m = 1'b1;
        wt(4);
        scl = 1'b1;
        wt(8);
        sda_m = 1'b0;
        wt(8);
        scl = 1'b0;
        wt(4);
    endtask
    task automatic stop_c;
        sda_m = 1'b0;
        wt(4);
        scl = 1'b1;
        wt(8);
        sda_m = 1'b1;
        wt(8);
    endtask
    task automatic bit_io(input logic b, output logic r);
        sda_m = b;
        wt(4);
        scl = 1'b1;
        wt(4);
        r = sda;
        wt(4);
        scl = 1'b0;
        wt(4);
    endtask
    task automatic byte_io(input logic [7:0] w, output logic [7:0] r);
        for (int i = 7; i >= 0; i--)
            bit_io(w[i], r[i]);
    endtask
endmodule
`default_nettype wire

/* expander_read_path_bench.sv */
/* Self-checking bench for the expander read path against a register model.
   Assumes the master model and checker are compiled before it. */
`timescale 1ns/1ps
`default_nettype none
module expander_read_path_bench;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic [2:0] asel = 3'h0;
    logic [7:0] pins = 8'h00;
    logic scl, sda_m, sda_out, sda_oe;
    logic [7:0] port_out, port_dir, port_polarity;
    logic [7:0] regs [4];
    logic [1:0] ptr;
    int error_cnt = 0;
    int tests_run = 0;
    wire logic sda = sda_m & (sda_oe ? sda_out : 1'b1);
    initial
    begin
        forever #4 mclk = ~mclk;
    end
    expander_read_path i_expander_read_path (.mclk(mclk), .rst_b(rst_b), .scl_in(scl),
        .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .addr_select_pins(asel),
        .port_pins(pins), .port_out(port_out), .port_dir(port_dir),
        .port_polarity(port_polarity));
    i2c_master_model i_i2c_master_model (.mclk(mclk), .sda(sda), .scl(scl), .sda_m(sda_m));
    // ========
    // Checks and model
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e)
        begin
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
            error_cnt++;
        end
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic model_reset;
        regs = '{8'h00, 8'h00, 8'hf0, 8'hff};
        ptr = 2'h0;
    endtask
    task automatic chk_regs;
        chk("port_out", regs[1], port_out);
        chk("port_polarity", regs[2], port_polarity);
        chk("port_dir", regs[3], port_dir);
    endtask
    task automatic snd(input logic [7:0] b, input logic hit);
        logic [7:0] r;
        logic k;
        i_i2c_master_model.byte_io(b, r);
        i_i2c_master_model.bit_io(1'b1, k);
        chk("ack", {7'h0, !hit}, {7'h0, k});
    endtask
    task automatic txn(input logic [7:0] cmd, input logic wcmd, input int nw, input int nr,
        input logic [2:0] a);
        logic [7:0] d;
        logic [7:0] r;
        logic k;
        logic hit;
        hit = (a == asel);
        i_i2c_master_model.start_c();
        if (wcmd)
        begin
            snd({4'h3, a, 1'b0}, hit);
            snd(cmd, hit);
            if (hit) ptr = cmd[1:0];
            for (int i = 0; i < nw; i++)
            begin
                d = $urandom;
                snd(d, hit);
                if (hit && ptr != 2'h0) regs[ptr] = d;
            end
            if (nr > 0) i_i2c_master_model.start_c();
        end
        if (nr > 0)
        begin
            snd({4'h3, a, 1'b1}, hit);
            for (int i = 0; i < nr; i++)
            begin
                i_i2c_master_model.byte_io(8'hff, r);
                d = hit ? ((ptr == 2'h0) ? pins ^ regs[2] : regs[ptr]) : 8'hff;
                chk("read", d, r);
                i_i2c_master_model.bit_io(i == nr - 1, k);
            end
        end
        i_i2c_master_model.stop_c();
        chk_regs();
    endtask
    // ========
    // Main sequence
    initial
    begin
        logic k;
        void'($urandom(32'ha9cf_a5ab));
        asel = $urandom;
        pins = $urandom;
        model_reset();
        repeat (5) @(negedge mclk);
        rst_b = 1'b1;
        i_i2c_master_model.wt(4);
        chk_regs();
        txn(8'h00, 1'b0, 0, 2, asel);
        for (int p = 0; p < 4; p++)
        begin
            pins = $urandom;
            txn({6'($urandom), 2'(p)}, 1'b1, 2, 3, asel);
        end
        txn(8'h01, 1'b1, 1, 1, asel ^ 3'h5);
        i_i2c_master_model.start_c();
        snd({4'h3, asel, 1'b0}, 1'b1);
        snd(8'h01, 1'b1);
        ptr = 2'h1;
        for (int i = 0; i < 4; i++)
            i_i2c_master_model.bit_io(~regs[1][7 - i], k);
        i_i2c_master_model.stop_c();
        chk_regs();
        txn(8'h00, 1'b0, 0, 2, asel);
        rst_b = 1'b0;
        repeat (2) @(negedge mclk);
        rst_b = 1'b1;
        model_reset();
        i_i2c_master_model.wt(4);
        chk_regs();
        txn(8'h00, 1'b0, 0, 1, asel);
        close_out();
    end
    initial
    begin
        #760000;
        error_cnt++;
        close_out();
    end
endmodule
`default_nettype wire
